// ### rtl/rtcac_top.sv
`timescale 1ns/1ps
`include "rtcac_defs.svh"

// What this block does
// - Weekday alarm is four bits, 1..7 with Sunday one; all ones ignores it.
// - Alarm PM flag bit 5 joins the hour compare only in twelve-hour mode.
// - Hour alarm is five bits, 0..23 or 1..12; all ones ignores it.
// - Month alarm is five bits, 1..12; all ones makes month don't-care.
// - Date alarm is six bits, 1..31; all ones ignores the date.
// - Control bit 15 selects coding of all time registers: binary or BCD.
// - Control bit 14 selects twelve-hour mode when 1, else twenty-four-hour.
// - Control bit 11 requests the seconds counter to halt; zero resumes.
// - Status bit 10 shows the actual seconds counter state, 1 when stopped.
// - Control bit 9, reset 1, requests alarms stopped; zero restores them.
// - Status bit 8, reset 1, shows the actual alarm circuitry state.
// - Minute and second alarms take 0..59; all ones ignores each field.
// - Current hour PM flag at bit 5 matters only in twelve-hour mode.
module rtcac_top
    import rtcac_pkg::*;
(
    input  wire logic        SYS_CLK,
    input  wire logic        NRST,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [15:0] REG_WDATA,
    input  wire logic        REG_WR,
    output logic      [15:0] REG_RDATA,
    input  wire logic        SEC_TICK,
    input  rtcac_time_s      CUR_TIME,
    input  wire logic [6:0]  ALARM_SECOND_VALUE,
    input  wire logic [6:0]  ALARM_MINUTE_VALUE,
    output logic             SEC_CNT_HALT,
    output logic             BCD_MODE,
    output logic             TWELVE_HOUR_SELECT,
    output logic             ALARM_EVT
);

    rtcac_state_s s_q;
    rtcac_state_s s_d;

    logic sec_ok;
    logic min_ok;
    logic hour_ok;
    logic wday_ok;
    logic date_ok;
    logic month_ok;
    logic all_match;
    logic running;
    logic wr_hd;
    logic wr_dm;
    logic wr_tc;

    // One clock domain, so all checks share one default clock and reset
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);

    // Address decode for the three registers of this block
    assign wr_hd = REG_WR && (REG_ADDR == `RTCAC_OFS_ALM_HOURS_DAY);
    assign wr_dm = REG_WR && (REG_ADDR == `RTCAC_OFS_ALM_DATE_MONTH);
    assign wr_tc = REG_WR && (REG_ADDR == `RTCAC_OFS_TIME_CTRL);

    // Per-field compare; all ones turns the field into a don't-care.
    // Raw codes are compared, so alarm and counters share one coding.
    assign sec_ok   = (ALARM_SECOND_VALUE == `RTCAC_IGN_7) ||
                      (ALARM_SECOND_VALUE == CUR_TIME.second);
    assign min_ok   = (ALARM_MINUTE_VALUE == `RTCAC_IGN_7) ||
                      (ALARM_MINUTE_VALUE == CUR_TIME.minute);
    assign wday_ok  = (s_q.weekday == `RTCAC_IGN_4) ||
                      (s_q.weekday == {1'b0, CUR_TIME.weekday});
    assign date_ok  = (s_q.date == `RTCAC_IGN_6) || (s_q.date == CUR_TIME.date);
    assign month_ok = (s_q.month == `RTCAC_IGN_5) || (s_q.month == CUR_TIME.month);

    // PM flags count only in twelve-hour mode; in 24h mode they are ignored
    // so a stale flag left by software cannot block the alarm.
    assign hour_ok  = (s_q.hour == `RTCAC_IGN_5) ||
                      ((s_q.hour == CUR_TIME.hour) &&
                       (!s_q.twelve || (s_q.pm == CUR_TIME.pm)));

    assign all_match = sec_ok && min_ok && hour_ok && wday_ok && date_ok && month_ok;
    assign running   = (s_q.alm == RTCAC_ALM_RUN);

    // Compare-path checks: a don't-care code must never block its field,
    // and the PM flags only count in twelve-hour mode with the hour kept.
    AST_WDAY_IGN: assert property (
        (s_q.weekday == 4'hf) |-> wday_ok)
        else $error("ignored weekday field blocked the match");

    AST_HOUR_IGN: assert property (
        (s_q.hour == 5'h1f) |-> hour_ok)
        else $error("ignored hour field blocked the match");

    AST_MONTH_IGN: assert property (
        (s_q.month == 5'h1f) |-> month_ok)
        else $error("ignored month field blocked the match");

    AST_DATE_IGN: assert property (
        (s_q.date == 6'h3f) |-> date_ok)
        else $error("ignored date field blocked the match");

    AST_SECMIN_IGN: assert property (
        (ALARM_SECOND_VALUE == 7'h7f && ALARM_MINUTE_VALUE == 7'h7f) |-> (sec_ok && min_ok))
        else $error("ignored second or minute field blocked the match");

    AST_PM_24H: assert property (
        (!s_q.twelve && s_q.hour == CUR_TIME.hour) |-> hour_ok)
        else $error("pm flag blocked an hour match in 24-hour mode");

    AST_PM_12H: assert property (
        (s_q.twelve && s_q.hour != 5'h1f && s_q.pm != CUR_TIME.pm) |-> !hour_ok)
        else $error("pm mismatch ignored in twelve-hour mode");

    // Next-state logic for the whole block
    always_comb begin
        s_d = s_q;

        // Alarm hours/day register; software is expected to stop alarms first
        if (wr_hd) begin
            s_d.weekday = REG_WDATA[`RTCAC_WDAY_MSB:`RTCAC_WDAY_LSB];
            s_d.pm      = REG_WDATA[`RTCAC_APM_BIT];
            s_d.hour    = REG_WDATA[`RTCAC_AHR_MSB:`RTCAC_AHR_LSB];
        end

        // Alarm date/month register
        if (wr_dm) begin
            s_d.month = REG_WDATA[`RTCAC_AMTH_MSB:`RTCAC_AMTH_LSB];
            s_d.date  = REG_WDATA[`RTCAC_ADATE_MSB:`RTCAC_ADATE_LSB];
        end

        // Time control; status bits are read only and ignore writes
        if (wr_tc) begin
            s_d.bcd          = REG_WDATA[`RTCAC_BIT_BCD];
            s_d.twelve       = REG_WDATA[`RTCAC_BIT_12HR];
            s_d.cnt_stop_req = REG_WDATA[`RTCAC_BIT_CNT_STOP];
            s_d.alm_stop_req = REG_WDATA[`RTCAC_BIT_ALM_STOP];
        end

        // Requests take effect only at a seconds boundary, so the status
        // bits lag the request bits until the next tick.
        if (SEC_TICK) begin
            s_d.cnt_stopped = s_q.cnt_stop_req;
            unique case (s_q.alm)
                RTCAC_ALM_RUN: begin
                    if (s_q.alm_stop_req) begin
                        s_d.alm = RTCAC_ALM_STOP;
                    end
                end
                RTCAC_ALM_STOP: begin
                    if (!s_q.alm_stop_req) begin
                        s_d.alm = RTCAC_ALM_RUN;
                    end
                end
                default: begin
                    s_d.alm = RTCAC_ALM_STOP;
                end
            endcase
        end

        // One pulse per matching period, only while alarms really run
        s_d.match_prev = all_match && running;
        s_d.alarm_evt  = all_match && running && !s_q.match_prev;

        // Registered read data, valid the cycle after the address
        unique case (REG_ADDR)
            `RTCAC_OFS_ALM_HOURS_DAY: begin
                s_d.rdata = {4'h0, s_q.weekday, 2'h0, s_q.pm, s_q.hour};
            end
            `RTCAC_OFS_ALM_DATE_MONTH: begin
                s_d.rdata = {3'h0, s_q.month, 2'h0, s_q.date};
            end
            `RTCAC_OFS_TIME_CTRL: begin
                s_d.rdata = {s_q.bcd, s_q.twelve, 2'h0, s_q.cnt_stop_req,
                             s_q.cnt_stopped, s_q.alm_stop_req,
                             (s_q.alm == RTCAC_ALM_STOP), 8'h00};
            end
            default: begin
                s_d.rdata = 16'h0000;
            end
        endcase
    end

    // State register with synchronous reset
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            s_q.weekday      <= `RTCAC_RST_WDAY;
            s_q.pm           <= `RTCAC_RST_APM;
            s_q.hour         <= `RTCAC_RST_AHR;
            s_q.month        <= `RTCAC_RST_AMTH;
            s_q.date         <= `RTCAC_RST_ADATE;
            s_q.bcd          <= `RTCAC_RST_BCD;
            s_q.twelve       <= `RTCAC_RST_12HR;
            s_q.cnt_stop_req <= `RTCAC_RST_CNT_STOP;
            s_q.cnt_stopped  <= `RTCAC_RST_CNT_STS;
            s_q.alm_stop_req <= `RTCAC_RST_ALM_STOP;
            s_q.alm          <= RTCAC_ALM_STOP;
            s_q.match_prev   <= 1'b0;
            s_q.alarm_evt    <= 1'b0;
            s_q.rdata        <= 16'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from flip-flops
    assign REG_RDATA          = s_q.rdata;
    assign ALARM_EVT          = s_q.alarm_evt;
    assign SEC_CNT_HALT       = s_q.cnt_stop_req;
    assign BCD_MODE           = s_q.bcd;
    assign TWELVE_HOUR_SELECT = s_q.twelve;

    // Checks on the alarm path, status bits and time control write

    AST_EVT_CAUSE: assert property (
        ALARM_EVT |-> $past(all_match && running))
        else $error("alarm event without a running match");

    AST_EVT_STOPPED: assert property (
        (s_q.alm == RTCAC_ALM_STOP) |=> !ALARM_EVT)
        else $error("alarm event while alarms stopped");

    AST_WEEKDAY: assert property (
        ALARM_EVT |-> $past(s_q.weekday == 4'hf || s_q.weekday == {1'b0, CUR_TIME.weekday}))
        else $error("alarm event with weekday mismatch");

    AST_HOUR_PM: assert property (
        (ALARM_EVT && $past(s_q.twelve && s_q.hour != 5'h1f)) |-> $past(s_q.pm == CUR_TIME.pm))
        else $error("alarm event with pm mismatch in twelve-hour mode");

    AST_HOUR: assert property (
        ALARM_EVT |-> $past(s_q.hour == 5'h1f || s_q.hour == CUR_TIME.hour))
        else $error("alarm event with hour mismatch");

    AST_MONTH: assert property (
        ALARM_EVT |-> $past(s_q.month == 5'h1f || s_q.month == CUR_TIME.month))
        else $error("alarm event with month mismatch");

    AST_DATE: assert property (
        ALARM_EVT |-> $past(s_q.date == 6'h3f || s_q.date == CUR_TIME.date))
        else $error("alarm event with date mismatch");

    AST_SECMIN: assert property (
        ALARM_EVT |-> $past(
            (ALARM_SECOND_VALUE == 7'h7f || ALARM_SECOND_VALUE == CUR_TIME.second) &&
            (ALARM_MINUTE_VALUE == 7'h7f || ALARM_MINUTE_VALUE == CUR_TIME.minute)))
        else $error("alarm event with second or minute mismatch");

    AST_CNT_STS: assert property (
        SEC_TICK |=> (s_q.cnt_stopped == $past(s_q.cnt_stop_req)))
        else $error("counter status did not follow request at tick");

    AST_ALM_STS: assert property (
        (SEC_TICK && !s_q.alm_stop_req) |=> (s_q.alm == RTCAC_ALM_RUN))
        else $error("alarm status did not resume at tick");

    AST_CTRL_WR: assert property (
        wr_tc |=> (BCD_MODE == $past(REG_WDATA[15]) && TWELVE_HOUR_SELECT == $past(REG_WDATA[14])))
        else $error("time control write not taken");

    // Register write checks: each field lands the cycle after its strobe
    AST_HD_WR: assert property (
        wr_hd |=> (s_q.weekday == $past(REG_WDATA[11:8]) && s_q.hour == $past(REG_WDATA[4:0])))
        else $error("hours/day alarm write not taken");

    AST_PM_WR: assert property (
        wr_hd |=> (s_q.pm == $past(REG_WDATA[5])))
        else $error("alarm pm flag write not taken");

    AST_DM_WR: assert property (
        wr_dm |=> (s_q.month == $past(REG_WDATA[12:8]) && s_q.date == $past(REG_WDATA[5:0])))
        else $error("date/month alarm write not taken");

    AST_CNT_REQ_WR: assert property (
        wr_tc |=> (SEC_CNT_HALT == $past(REG_WDATA[11])))
        else $error("counter stop request write not taken");

    AST_ALM_REQ_WR: assert property (
        wr_tc |=> (s_q.alm_stop_req == $past(REG_WDATA[9])))
        else $error("alarm stop request write not taken");

    // Status bits move only at a tick, and then to the requested state
    AST_CNT_HOLD: assert property (
        !SEC_TICK |=> (s_q.cnt_stopped == $past(s_q.cnt_stopped)))
        else $error("counter status changed without a tick");

    AST_ALM_HOLD: assert property (
        !SEC_TICK |=> (s_q.alm == $past(s_q.alm)))
        else $error("alarm status changed without a tick");

    AST_ALM_STOP_TICK: assert property (
        (SEC_TICK && s_q.alm_stop_req) |=> (s_q.alm == RTCAC_ALM_STOP))
        else $error("alarms not stopped at tick");

    AST_RD_STATUS: assert property (
        (REG_ADDR == `RTCAC_OFS_TIME_CTRL) |=> (REG_RDATA[10] == $past(s_q.cnt_stopped)
            && REG_RDATA[8] == $past(s_q.alm == RTCAC_ALM_STOP)))
        else $error("status bits read back wrong");

    // Event shape: raised the cycle after the first matching cycle, then one cycle only
    AST_EVT_RAISE: assert property (
        (all_match && running && !s_q.match_prev) |=> ALARM_EVT)
        else $error("running match raised no alarm event");

    AST_EVT_PULSE: assert property (
        ALARM_EVT |=> !ALARM_EVT)
        else $error("alarm event wider than one cycle");

endmodule : rtcac_top

// ### rtl/rtcac_defs.svh
`ifndef RTCAC_DEFS_SVH
`define RTCAC_DEFS_SVH

// Register offsets on the control interface
`define RTCAC_OFS_ALM_HOURS_DAY   8'h15
`define RTCAC_OFS_ALM_DATE_MONTH  8'h16
`define RTCAC_OFS_TIME_CTRL       8'h17

// Alarm hours/day field positions
`define RTCAC_WDAY_MSB            11
`define RTCAC_WDAY_LSB            8
`define RTCAC_APM_BIT             5
`define RTCAC_AHR_MSB             4
`define RTCAC_AHR_LSB             0

// Alarm date/month field positions
`define RTCAC_AMTH_MSB            12
`define RTCAC_AMTH_LSB            8
`define RTCAC_ADATE_MSB           5
`define RTCAC_ADATE_LSB           0

// Time control bit positions
`define RTCAC_BIT_BCD             15
`define RTCAC_BIT_12HR            14
`define RTCAC_BIT_CNT_STOP        11
`define RTCAC_BIT_CNT_STS         10
`define RTCAC_BIT_ALM_STOP        9
`define RTCAC_BIT_ALM_STS         8

// Reset values
`define RTCAC_RST_WDAY            4'h0
`define RTCAC_RST_APM             1'b0
`define RTCAC_RST_AHR             5'h00
`define RTCAC_RST_AMTH            5'h00
`define RTCAC_RST_ADATE           6'h00
`define RTCAC_RST_BCD             1'b0
`define RTCAC_RST_12HR            1'b0
`define RTCAC_RST_CNT_STOP        1'b0
`define RTCAC_RST_CNT_STS         1'b0
`define RTCAC_RST_ALM_STOP        1'b1

// Don't-care codes (all ones per field width)
`define RTCAC_IGN_7               7'h7f
`define RTCAC_IGN_6               6'h3f
`define RTCAC_IGN_5               5'h1f
`define RTCAC_IGN_4               4'hf

`endif

// ### rtl/rtcac_pkg.sv
package rtcac_pkg;

    // Current time as presented by the time counters
    typedef struct packed {
        logic [6:0] second;
        logic [6:0] minute;
        logic       pm;
        logic [4:0] hour;
        logic [2:0] weekday;
        logic [5:0] date;
        logic [4:0] month;
    } rtcac_time_s;

    // Actual alarm circuitry state
    typedef enum logic [1:0] {
        RTCAC_ALM_RUN  = 2'b01,
        RTCAC_ALM_STOP = 2'b10
    } rtcac_alm_e;

    // Whole state of the block
    typedef struct packed {
        logic [3:0]  weekday;
        logic        pm;
        logic [4:0]  hour;
        logic [4:0]  month;
        logic [5:0]  date;
        logic        bcd;
        logic        twelve;
        logic        cnt_stop_req;
        logic        cnt_stopped;
        logic        alm_stop_req;
        rtcac_alm_e  alm;
        logic        match_prev;
        logic        alarm_evt;
        logic [15:0] rdata;
    } rtcac_state_s;

endpackage : rtcac_pkg

// ### verification/tb_rtcac_top.sv
`timescale 1ns/1ps
`include "rtcac_defs.svh"

module tb_rtcac_top;
    import rtcac_pkg::*;
    localparam logic [7:0] A_HD = `RTCAC_OFS_ALM_HOURS_DAY;
    localparam logic [7:0] A_DM = `RTCAC_OFS_ALM_DATE_MONTH;
    localparam logic [7:0] A_TC = `RTCAC_OFS_TIME_CTRL;
    localparam rtcac_time_s IDLE_T = {7'h3a, 7'h3b, 1'b0, 5'h00, 3'h0, 6'h00, 5'h00};
    logic        SYS_CLK            = 1'b0;
    logic        NRST               = 1'b0;
    logic [7:0]  REG_ADDR           = 8'h00;
    logic [15:0] REG_WDATA          = 16'h0000;
    logic        REG_WR             = 1'b0;
    logic        SEC_TICK           = 1'b0;
    rtcac_time_s CUR_TIME           = IDLE_T;
    logic [6:0]  ALARM_SECOND_VALUE = 7'h10;
    logic [6:0]  ALARM_MINUTE_VALUE = 7'h11;
    logic [15:0] REG_RDATA;
    logic        SEC_CNT_HALT;
    logic        BCD_MODE;
    logic        TWELVE_HOUR_SELECT;
    logic        ALARM_EVT;
    logic        rd_req      = 1'b0;
    logic        rd_d        = 1'b0;
    logic [15:0] rd_q[$];
    bit          ev_q[$];
    int          n_errors    = 0;
    int          checks_done = 0;
    logic [15:0] ctl         = 16'h0200;
    logic        cnt_sts     = 1'b0;
    logic        alm_sts     = 1'b1;
    logic [15:0] r;

    rtcac_top i_dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RDATA(REG_RDATA), .SEC_TICK(SEC_TICK), .CUR_TIME(CUR_TIME),
        .ALARM_SECOND_VALUE(ALARM_SECOND_VALUE), .ALARM_MINUTE_VALUE(ALARM_MINUTE_VALUE),
        .SEC_CNT_HALT(SEC_CNT_HALT), .BCD_MODE(BCD_MODE),
        .TWELVE_HOUR_SELECT(TWELVE_HOUR_SELECT), .ALARM_EVT(ALARM_EVT));

    always #25 SYS_CLK = ~SYS_CLK;

    task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk16

    task automatic chk1(string what, logic exp, logic got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    // Read data lands one edge after the address is taken
    always @(posedge SYS_CLK) begin
        rd_d <= rd_req;
        if (rd_d && rd_q.size() > 0) chk16("REG_RDATA", rd_q.pop_front(), REG_RDATA);
        if (NRST && ALARM_EVT !== 1'b0) begin
            chk1("ALARM_EVT", ev_q.size() > 0, ALARM_EVT);
            if (ev_q.size() > 0) void'(ev_q.pop_front());
        end
    end

    task automatic idle(int n);
        repeat (n) begin
            @(posedge SYS_CLK);
            REG_WR   <= 1'b0;
            rd_req   <= 1'b0;
            SEC_TICK <= 1'b0;
        end
    endtask : idle

    task automatic wr(logic [7:0] a, logic [15:0] d);
        @(posedge SYS_CLK);
        {REG_ADDR, REG_WDATA, REG_WR, rd_req, SEC_TICK} <= {a, d, 3'b100};
        if (a == A_TC) ctl = d & 16'hca00; // Status bits not writable
    endtask : wr

    task automatic rd(logic [7:0] a, logic [15:0] exp);
        @(posedge SYS_CLK);
        {REG_ADDR, REG_WR, rd_req, SEC_TICK} <= {a, 3'b010};
        rd_q.push_back(exp);
    endtask : rd

    // Status copies the requests only at a seconds tick
    task automatic tick();
        @(posedge SYS_CLK);
        {REG_WR, rd_req, SEC_TICK} <= 3'b001;
        cnt_sts = ctl[11];
        alm_sts = ctl[9];
    endtask : tick

    function automatic logic [15:0] ctl_exp();
        return ctl | {5'h00, cnt_sts, 1'b0, alm_sts, 8'h00};
    endfunction : ctl_exp

    function automatic rtcac_time_s mk(logic pm, logic [4:0] h, logic [2:0] w, logic [5:0] d,
                                       logic [4:0] m);
        return {7'h10, 7'h11, pm, h, w, d, m};
    endfunction : mk

    // Alarms stopped around field rewrites, so setup never raises events
    task automatic acase(logic [15:0] hd, logic [15:0] dm, logic [15:0] c, rtcac_time_s t,
                         logic [6:0] asec, bit exp);
        wr(A_TC, c | 16'h0200);
        tick();
        wr(A_HD, hd);
        wr(A_DM, dm);
        ALARM_SECOND_VALUE <= asec;
        wr(A_TC, c);
        tick();
        idle(2);
        if (exp) ev_q.push_back(1'b1);
        CUR_TIME <= t;
        idle(4);
        CUR_TIME <= IDLE_T;
        idle(2);
        chk1("alarm event count", 1'b1, ev_q.size() == 0);
    endtask : acase

    task automatic results();
        $display("Checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    initial begin
        repeat (4000) @(posedge SYS_CLK);
        n_errors++;
        results();
    end

    initial begin
        void'($urandom(32'h7bb7));
        repeat (8) @(posedge SYS_CLK);
        NRST <= 1'b1;
        rd(A_HD, 16'h0000);
        rd(A_DM, 16'h0000);
        rd(A_TC, 16'h0300);
        idle(2);
        chk1("SEC_CNT_HALT", 1'b0, SEC_CNT_HALT);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            r = 16'($urandom());
            wr(A_HD, r);
            wr(A_DM, ~r);
            wr(8'h20, r);
            wr(A_TC, r);
            rd(A_HD, r & 16'h0f3f);
            rd(A_DM, ~r & 16'h1f3f);
            rd(A_TC, ctl_exp());
            rd(8'h20, 16'h0000);
            idle(2);
            chk1("BCD_MODE", r[15], BCD_MODE);
            chk1("TWELVE_HOUR_SELECT", r[14], TWELVE_HOUR_SELECT);
            chk1("SEC_CNT_HALT", r[11], SEC_CNT_HALT);
        end
        $display("register test done");
        for (int i = 0; i < 2; i++) begin
            wr(A_TC, i ? 16'h0200 : 16'h0800);
            rd(A_TC, ctl_exp());
            tick();
            idle(1);
            rd(A_TC, ctl_exp());
        end
        $display("status test done");
        acase(16'h0305, 16'h0714, 16'h0000, mk(1'b0, 5'h05, 3'h3, 6'h14, 5'h07),
              7'h10, 1'b1);
        acase(16'h0305, 16'h0714, 16'h0000, mk(1'b0, 5'h06, 3'h3, 6'h14, 5'h07),
              7'h10, 1'b0);
        acase(16'h0305, 16'h0714, 16'h0000, mk(1'b0, 5'h05, 3'h4, 6'h14, 5'h07),
              7'h10, 1'b0);
        acase(16'h0f05, 16'h0714, 16'h0000, mk(1'b0, 5'h05, 3'h5, 6'h14, 5'h07),
              7'h10, 1'b1);
        acase(16'h0305, 16'h0714, 16'h0000, mk(1'b0, 5'h05, 3'h3, 6'h15, 5'h07),
              7'h10, 1'b0);
        acase(16'h0305, 16'h0714, 16'h0000, mk(1'b0, 5'h05, 3'h3, 6'h14, 5'h08),
              7'h10, 1'b0);
        acase(16'h0305, 16'h1f3f, 16'h0000, mk(1'b0, 5'h05, 3'h3, 6'h09, 5'h02),
              7'h10, 1'b1);
        acase(16'h033f, 16'h0714, 16'h0000, mk(1'b0, 5'h11, 3'h3, 6'h14, 5'h07),
              7'h10, 1'b1);
        acase(16'h0305, 16'h0714, 16'h0000, mk(1'b1, 5'h05, 3'h3, 6'h14, 5'h07),
              7'h10, 1'b1);
        acase(16'h0325, 16'h0714, 16'h4000, mk(1'b0, 5'h05, 3'h3, 6'h14, 5'h07),
              7'h10, 1'b0);
        acase(16'h0325, 16'h0714, 16'h4000, mk(1'b1, 5'h05, 3'h3, 6'h14, 5'h07),
              7'h10, 1'b1);
        acase(16'h0305, 16'h0714, 16'h0000, mk(1'b0, 5'h05, 3'h3, 6'h14, 5'h07),
              7'h7f, 1'b1);
        acase(16'h0305, 16'h0714, 16'h0000, mk(1'b0, 5'h05, 3'h3, 6'h14, 5'h07),
              7'h11, 1'b0);
        acase(16'h0305, 16'h0714, 16'h0200, mk(1'b0, 5'h05, 3'h3, 6'h14, 5'h07),
              7'h10, 1'b0);
        acase(16'h0305, 16'h0714, 16'h8000, mk(1'b0, 5'h05, 3'h3, 6'h14, 5'h07),
              7'h10, 1'b1);
        $display("alarm test done");
        results();
    end
endmodule : tb_rtcac_top
